// ### common/spm_if.sv
`timescale 1ns/1ps
// Serial link between host and device; the output line idles high when undriven.
interface spm_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;

  // Resolve the three-state output into a plain level for the host.
  assign so_line = so_oe ? so : 1'b1;

  modport dev (
    input cs_n,
    input sck,
    input si,
    output so,
    output so_oe
  );

  modport host (
    output cs_n,
    output sck,
    output si,
    input so_line
  );
endinterface

// ### common/spm_pkg.sv
// How it works
// - Sixteen map bytes, byte n guards sector n.
// - FFH protects, 00H unprotects, others undefined.
// - Byte 0 bits 7:6 guard 0a, 5:4 0b.
// - Map reads all zeros after reset.
// - Host erases map before programming it.
// - Erase opcode 3D 2A 7F CF, deselect starts.
// - Busy during erase, then every byte reads FFH.
// - Erase accepted with protection on or off.
// - Program opcode 3D 2A 7F FC, sixteen bytes.
// - Deselect after data starts timed program, busy shown.
// - Bytes not received leave their sectors undefined.
// - Data past sixteenth byte wraps to location 0.
// - Program accepted with protection on or off.
// - Program overwrites internal buffer 1.
// - Read opcode 32, three dummies, sector 0 first.
// - Bits after sixteenth byte are undefined.
// - Deselect ends read, output goes undriven.
// - Host keeps map rewrites under ten thousand.
// - Marked sectors blocked only while protection enabled.
// - Write protect pin low rejects erase and program.
package spm_pkg;

  // Opcode bytes of the map commands and the status read.
  localparam logic [7:0] OP_PREFIX0 = 8'h3D;
  localparam logic [7:0] OP_PREFIX1 = 8'h2A;
  localparam logic [7:0] OP_PREFIX2 = 8'h7F;
  localparam logic [7:0] OP_MAP_ERASE = 8'hCF;
  localparam logic [7:0] OP_MAP_PROG = 8'hFC;
  localparam logic [7:0] OP_MAP_READ = 8'h32;
  localparam logic [7:0] OP_STATUS = 8'hD7;

  // Map geometry and byte values.
  localparam int MAP_BYTES = 16;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam logic [7:0] MAP_ERASED = 8'hFF;
  localparam logic [4:0] HDR_BYTES = 5'h04;
  localparam int SUB0A_HI = 7;
  localparam int SUB0A_LO = 6;
  localparam int SUB0B_HI = 5;
  localparam int SUB0B_LO = 4;
  localparam int STATUS_READY_BIT = 7;

  // Self-timed cycles; times round down to whole clocks, never below one.
  localparam int CLK_PERIOD_NS = 10;
  localparam int MAP_ERASE_TIME_NS = 2000;
  localparam int MAP_PROG_TIME_NS = 1000;
  localparam int ERASE_CYCLES = (MAP_ERASE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : MAP_ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (MAP_PROG_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : MAP_PROG_TIME_NS / CLK_PERIOD_NS;

  // Host transfer lengths in bits.
  localparam int XFER_W = 160;
  localparam logic [7:0] BITS_ERASE = 8'h20;
  localparam logic [7:0] BITS_LONG = 8'hA0;
  localparam logic [7:0] BITS_STATUS = 8'h10;

  // Commands that the host user side may request.
  typedef enum logic [1:0] {
    CMD_ERASE = 2'h0,
    CMD_PROG = 2'h1,
    CMD_READ = 2'h2,
    CMD_STATUS = 2'h3
  } spm_cmd_e;

endpackage

// ### src/spm_dev.sv
`timescale 1ns/1ps
// Device end: serial command decode, protection map, timed erase and program.
module spm_dev (
  input wire logic clk,
  input wire logic srst,
  spm_if.dev link,
  input wire logic wp_n,
  input wire logic prot_en,
  output logic busy,
  output logic buf1_clobber,
  output logic [16:0] blocked
);

  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_ERASE = 3'b010,
    D_PROG = 3'b100
  } spm_dstate_e;

  spm_dstate_e state;
  spm_dstate_e next_state;
  logic [15:0] tmr;
  logic [15:0] next_tmr;
  logic sck_q;
  logic cs_q;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [4:0] byte_cnt;
  logic [4:0] next_byte_cnt;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic [3:0] ptr;
  logic [3:0] next_ptr;
  logic [7:0] cmd [4];
  logic [7:0] next_cmd [4];
  logic [7:0] map [spm_pkg::MAP_BYTES];
  logic [7:0] next_map [spm_pkg::MAP_BYTES];
  logic [7:0] buf1 [spm_pkg::MAP_BYTES];
  logic [7:0] next_buf1 [spm_pkg::MAP_BYTES];
  logic so_r;
  logic next_so;
  logic so_oe_r;
  logic next_so_oe;
  logic next_busy;
  logic next_clobber;
  logic [16:0] next_blocked;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic glob_prot;
  logic out_phase;
  logic [7:0] byte_v;
  logic [7:0] rd_byte;
  logic [4:0] rd_idx;

  // True when the three prefix bytes and the given fourth byte were shifted in.
  function automatic logic prefixed(input logic [7:0] c0, input logic [7:0] c1,
                                    input logic [7:0] c2, input logic [7:0] c3,
                                    input logic [7:0] op);
    prefixed = (c0 == spm_pkg::OP_PREFIX0) && (c1 == spm_pkg::OP_PREFIX1) &&
               (c2 == spm_pkg::OP_PREFIX2) && (c3 == op);
  endfunction

  assign link.so = so_r;
  assign link.so_oe = so_oe_r;

  // Edges of the serial clock and chip select; both ends share clk, so no synchroniser.
  assign sck_rise = link.sck & ~sck_q;
  assign sck_fall = ~link.sck & sck_q;
  assign cs_rise = link.cs_n & ~cs_q;
  assign glob_prot = prot_en | ~wp_n;
  assign byte_v = {sh[6:0], link.si};
  assign rd_idx = byte_cnt - spm_pkg::HDR_BYTES;

  // Byte presented during the output phase of a read or status command.
  always_comb begin
    rd_byte = 8'h00;
    out_phase = 1'b0;
    if (cmd[0] == spm_pkg::OP_STATUS && byte_cnt != 5'h00) begin
      out_phase = 1'b1;
      rd_byte[spm_pkg::STATUS_READY_BIT] = (state == D_IDLE);
    end else if (cmd[0] == spm_pkg::OP_MAP_READ && byte_cnt >= spm_pkg::HDR_BYTES) begin
      out_phase = 1'b1;
      // Past the sixteenth byte the line carries zeros; nothing wraps.
      if (rd_idx < 5'h10) begin
        rd_byte = map[rd_idx[3:0]];
      end
    end
  end

  // Shift engine, command acceptance and the self-timed cycles.
  always_comb begin
    next_state = state;
    next_tmr = tmr;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_sh = sh;
    next_ptr = ptr;
    next_cmd = cmd;
    next_map = map;
    next_buf1 = buf1;
    next_so = so_r;
    next_so_oe = so_oe_r;
    next_clobber = 1'b0;
    if (link.cs_n) begin
      next_bit_cnt = 3'h0;
      next_byte_cnt = 5'h00;
      next_ptr = 4'h0;
      next_so_oe = 1'b0;
    end else begin
      if (sck_rise) begin
        next_sh = byte_v;
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          if (byte_cnt < spm_pkg::HDR_BYTES) begin
            next_cmd[byte_cnt[1:0]] = byte_v;
          end else if (prefixed(cmd[0], cmd[1], cmd[2], cmd[3], spm_pkg::OP_MAP_PROG)) begin
            // Data bytes land in buffer 1 in sector order.
            next_buf1[ptr] = byte_v;
            next_ptr = ptr + 4'h1;
            next_clobber = (byte_cnt == spm_pkg::HDR_BYTES);
          end
          // Saturate so a long stream cannot fold back into the header.
          if (byte_cnt != 5'h1F) begin
            next_byte_cnt = byte_cnt + 5'h01;
          end
        end
      end
      if (sck_fall && out_phase) begin
        next_so_oe = 1'b1;
        next_so = rd_byte[~bit_cnt];
      end
    end

    unique case (state)
      D_IDLE: begin
        // Deselect on a whole-byte boundary starts a write unless the pin protects the map.
        if (cs_rise && wp_n && bit_cnt == 3'h0) begin
          if (byte_cnt == spm_pkg::HDR_BYTES &&
              prefixed(cmd[0], cmd[1], cmd[2], cmd[3], spm_pkg::OP_MAP_ERASE)) begin
            next_state = D_ERASE;
            next_tmr = 16'(spm_pkg::ERASE_CYCLES - 1);
          end else if (byte_cnt > spm_pkg::HDR_BYTES &&
                       prefixed(cmd[0], cmd[1], cmd[2], cmd[3], spm_pkg::OP_MAP_PROG)) begin
            next_state = D_PROG;
            next_tmr = 16'(spm_pkg::PROG_CYCLES - 1);
          end
        end
      end
      D_ERASE: begin
        if (tmr == 16'h0000) begin
          next_state = D_IDLE;
          for (int i = 0; i < spm_pkg::MAP_BYTES; i++) begin
            next_map[i] = spm_pkg::MAP_ERASED;
          end
        end else begin
          next_tmr = tmr - 16'h0001;
        end
      end
      D_PROG: begin
        if (tmr == 16'h0000) begin
          next_state = D_IDLE;
          // Programming only clears bits, so it is meaningful only on an erased map.
          // Locations never received keep stale buffer content and are thus undefined.
          for (int i = 0; i < spm_pkg::MAP_BYTES; i++) begin
            next_map[i] = map[i] & buf1[i];
          end
        end else begin
          next_tmr = tmr - 16'h0001;
        end
      end
      default: begin
        // A corrupted one-hot code falls back to idle rather than hanging busy.
        next_state = D_IDLE;
      end
    endcase
    next_busy = (next_state != D_IDLE);
  end

  // Sector blocking follows the map only while global protection is on.
  always_comb begin
    next_blocked[0] = glob_prot & map[0][spm_pkg::SUB0A_HI] & map[0][spm_pkg::SUB0A_LO];
    next_blocked[1] = glob_prot & map[0][spm_pkg::SUB0B_HI] & map[0][spm_pkg::SUB0B_LO];
    for (int k = 1; k < spm_pkg::MAP_BYTES; k++) begin
      next_blocked[k + 1] = glob_prot & (map[k] == spm_pkg::MAP_ERASED);
    end
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= D_IDLE;
      tmr <= 16'h0000;
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      bit_cnt <= 3'h0;
      byte_cnt <= 5'h00;
      sh <= 8'h00;
      ptr <= 4'h0;
      so_r <= 1'b0;
      so_oe_r <= 1'b0;
      busy <= 1'b0;
      buf1_clobber <= 1'b0;
      blocked <= 17'h0_0000;
      for (int i = 0; i < 4; i++) begin
        cmd[i] <= 8'h00;
      end
      for (int i = 0; i < spm_pkg::MAP_BYTES; i++) begin
        map[i] <= spm_pkg::MAP_RESET;
        buf1[i] <= 8'h00;
      end
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      sck_q <= link.sck;
      cs_q <= link.cs_n;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      sh <= next_sh;
      ptr <= next_ptr;
      so_r <= next_so;
      so_oe_r <= next_so_oe;
      busy <= next_busy;
      buf1_clobber <= next_clobber;
      blocked <= next_blocked;
      cmd <= next_cmd;
      map <= next_map;
      buf1 <= next_buf1;
    end
  end

endmodule

// ### src/spm_host.sv
`timescale 1ns/1ps
// Host end: issues one map or status command per start and polls status after writes.
module spm_host #(
  parameter int HALF_DIV = 5
) (
  input wire logic clk,
  input wire logic srst,
  spm_if.host link,
  input wire logic start,
  input wire spm_pkg::spm_cmd_e cmd,
  input wire logic [127:0] wr_map,
  output logic ready,
  output logic done,
  output logic [127:0] rd_map,
  output logic [7:0] status_out
);

  // The device needs a few clocks to see an edge and answer before the next one.
  if (HALF_DIV < 4 || HALF_DIV > 255) begin : g_chk
    $error("HALF_DIV must lie between 4 and 255");
  end

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_SHIFT = 3'b010,
    H_GAP = 3'b100
  } spm_hstate_e;

  spm_hstate_e st;
  spm_hstate_e next_st;
  logic [7:0] div;
  logic [7:0] next_div;
  logic sck_r;
  logic next_sck;
  logic cs_n_r;
  logic next_cs_n;
  logic si_r;
  logic next_si;
  logic [spm_pkg::XFER_W-1:0] tx;
  logic [spm_pkg::XFER_W-1:0] next_tx;
  logic [spm_pkg::XFER_W-1:0] rx;
  logic [spm_pkg::XFER_W-1:0] next_rx;
  logic [7:0] nbits;
  logic [7:0] next_nbits;
  logic [7:0] bcnt;
  logic [7:0] next_bcnt;
  logic polling;
  logic next_polling;
  spm_pkg::spm_cmd_e cmd_q;
  spm_pkg::spm_cmd_e next_cmd_q;
  logic next_ready;
  logic next_done;
  logic [127:0] next_rd_map;
  logic [7:0] next_status;
  logic tick;

  assign link.sck = sck_r;
  assign link.cs_n = cs_n_r;
  assign link.si = si_r;
  assign tick = (div == 8'h00);

  // Sequencer: select, clock out the frame, deselect, then poll or finish.
  always_comb begin
    next_st = st;
    next_div = tick ? 8'(HALF_DIV - 1) : div - 8'h01;
    next_sck = sck_r;
    next_cs_n = cs_n_r;
    next_tx = tx;
    next_rx = rx;
    next_nbits = nbits;
    next_bcnt = bcnt;
    next_polling = polling;
    next_cmd_q = cmd_q;
    next_done = 1'b0;
    next_rd_map = rd_map;
    next_status = status_out;
    unique case (st)
      H_IDLE: begin
        if (start) begin
          next_cmd_q = cmd;
          next_polling = 1'b0;
          next_cs_n = 1'b0;
          next_bcnt = 8'h00;
          next_div = 8'(HALF_DIV - 1);
          next_st = H_SHIFT;
          unique case (cmd)
            spm_pkg::CMD_ERASE: begin
              next_tx = {spm_pkg::OP_PREFIX0, spm_pkg::OP_PREFIX1, spm_pkg::OP_PREFIX2,
                         spm_pkg::OP_MAP_ERASE, 128'h0};
              next_nbits = spm_pkg::BITS_ERASE;
            end
            spm_pkg::CMD_PROG: begin
              next_tx = {spm_pkg::OP_PREFIX0, spm_pkg::OP_PREFIX1, spm_pkg::OP_PREFIX2,
                         spm_pkg::OP_MAP_PROG, wr_map};
              next_nbits = spm_pkg::BITS_LONG;
            end
            spm_pkg::CMD_READ: begin
              next_tx = {spm_pkg::OP_MAP_READ, 24'h00_0000, 128'h0};
              next_nbits = spm_pkg::BITS_LONG;
            end
            spm_pkg::CMD_STATUS: begin
              next_tx = {spm_pkg::OP_STATUS, 152'h0};
              next_nbits = spm_pkg::BITS_STATUS;
            end
          endcase
        end
      end
      H_SHIFT: begin
        if (tick) begin
          if (!sck_r) begin
            // Mode 0: the device samples on this rise; the host samples its answer too.
            next_sck = 1'b1;
            next_rx = {rx[spm_pkg::XFER_W-2:0], link.so_line};
            next_bcnt = bcnt + 8'h01;
          end else begin
            next_sck = 1'b0;
            if (bcnt == nbits) begin
              next_cs_n = 1'b1;
              next_st = H_GAP;
            end else begin
              next_tx = {tx[spm_pkg::XFER_W-2:0], 1'b0};
            end
          end
        end
      end
      H_GAP: begin
        if (tick) begin
          if ((cmd_q == spm_pkg::CMD_ERASE || cmd_q == spm_pkg::CMD_PROG) &&
              (!polling || !rx[spm_pkg::STATUS_READY_BIT])) begin
            // Keep polling status until the write cycle reports ready.
            next_polling = 1'b1;
            next_tx = {spm_pkg::OP_STATUS, 152'h0};
            next_nbits = spm_pkg::BITS_STATUS;
            next_bcnt = 8'h00;
            next_cs_n = 1'b0;
            next_st = H_SHIFT;
          end else begin
            next_done = 1'b1;
            next_st = H_IDLE;
            if (cmd_q == spm_pkg::CMD_READ) begin
              next_rd_map = rx[127:0];
            end else begin
              next_status = rx[7:0];
            end
          end
        end
      end
      default: begin
        next_st = H_IDLE;
        next_cs_n = 1'b1;
        next_sck = 1'b0;
      end
    endcase
    next_si = next_tx[spm_pkg::XFER_W-1];
    next_ready = (next_st == H_IDLE);
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      st <= H_IDLE;
      div <= 8'h00;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      si_r <= 1'b0;
      tx <= '0;
      rx <= '0;
      nbits <= 8'h00;
      bcnt <= 8'h00;
      polling <= 1'b0;
      cmd_q <= spm_pkg::CMD_ERASE;
      ready <= 1'b0;
      done <= 1'b0;
      rd_map <= 128'h0;
      status_out <= 8'h00;
    end else begin
      st <= next_st;
      div <= next_div;
      sck_r <= next_sck;
      cs_n_r <= next_cs_n;
      si_r <= next_si;
      tx <= next_tx;
      rx <= next_rx;
      nbits <= next_nbits;
      bcnt <= next_bcnt;
      polling <= next_polling;
      cmd_q <= next_cmd_q;
      ready <= next_ready;
      done <= next_done;
      rd_map <= next_rd_map;
      status_out <= next_status;
    end
  end

endmodule

// ### testbench/spm_chk_sva.sv
`timescale 1ns/1ps
// Watches the serial link and the device's status outputs from beside the interface.
module spm_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic so,
  input wire logic so_oe,
  input wire logic wp_n,
  input wire logic prot_en,
  input wire logic busy,
  input wire logic buf1_clobber,
  input wire logic [16:0] blocked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic [8:0] busy_len;
  logic [8:0] next_busy_len;

  // Length of the current busy run, so the self-timed cycles can be measured without long repetitions.
  always_comb begin
    next_busy_len = busy ? busy_len + 9'h001 : 9'h000;
  end

  always_ff @(posedge clk) begin
    busy_len <= srst ? 9'h000 : next_busy_len;
  end

  property p_busy_len;
    $fell(busy) |-> (busy_len == spm_pkg::ERASE_CYCLES) || (busy_len == spm_pkg::PROG_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy run has wrong length");

  property p_busy_start;
    $rose(busy) |-> cs_n && $past(cs_n);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy rose while selected");

  property p_wp_block;
    $rose(busy) |-> $past(wp_n) && $past(wp_n, 2);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("write cycle started while write protected");

  property p_no_block;
    !prot_en && wp_n && $stable(prot_en) && $stable(wp_n) |=> blocked == 17'h0_0000;
  endproperty
  a_no_block: assert property (p_no_block) else $error("sector blocked with protection off");

  property p_erase_full;
    $fell(busy) && busy_len == spm_pkg::ERASE_CYCLES && prot_en |-> ##[0:2] blocked == 17'h1_FFFF;
  endproperty
  a_erase_full: assert property (p_erase_full) else $error("erased map does not block every sector");

  property p_oe_release;
    cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |-> !so_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("output still driven after deselect");

  // The output only moves one clock after a falling serial edge, so it is quiet through a high phase.
  property p_so_hold;
    sck && $past(sck, 2) && so_oe && $past(so_oe) |-> $stable(so);
  endproperty
  a_so_hold: assert property (p_so_hold) else $error("output changed during high serial phase");

  property p_clobber;
    buf1_clobber |-> !cs_n ##1 !buf1_clobber;
  endproperty
  a_clobber: assert property (p_clobber) else $error("buffer overwrite pulse malformed");

  c_erase: cover property ($fell(busy) && busy_len == spm_pkg::ERASE_CYCLES);
  c_prog: cover property ($fell(busy) && busy_len == spm_pkg::PROG_CYCLES);
  c_read: cover property ($rose(so_oe));
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
// Drives the host user side and judges map contents and the device's protection outputs.
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  spm_pkg::spm_cmd_e cmd = spm_pkg::CMD_READ;
  logic [127:0] wr_map = 128'h0;
  logic wp_n = 1'b1;
  logic prot_en = 1'b0;
  logic ready;
  logic done;
  logic [127:0] rd_map;
  logic [7:0] status_out;
  logic busy;
  logic buf1_clobber;
  logic [16:0] blocked;
  int failures = 0;
  int cmp_count = 0;
  int clob_n = 0;
  // Sector 0 carries low bits that must be ignored; the rest alternate protected and open.
  localparam logic [127:0] PAT = {8'hCA, {7{16'hFF00}}, 8'hFF};

  spm_if i_spm_if ();
  spm_dev i_spm_dev (.clk(clk), .srst(srst), .link(i_spm_if.dev), .wp_n(wp_n), .prot_en(prot_en),
    .busy(busy), .buf1_clobber(buf1_clobber), .blocked(blocked));
  spm_host i_spm_host (.clk(clk), .srst(srst), .link(i_spm_if.host), .start(start), .cmd(cmd),
    .wr_map(wr_map), .ready(ready), .done(done), .rd_map(rd_map), .status_out(status_out));
  spm_chk chk (.clk(clk), .srst(srst), .cs_n(i_spm_if.cs_n), .sck(i_spm_if.sck), .so(i_spm_if.so),
    .so_oe(i_spm_if.so_oe), .wp_n(wp_n), .prot_en(prot_en), .busy(busy), .buf1_clobber(buf1_clobber),
    .blocked(blocked));

  // Free-running system clock.
  always #5 clk = ~clk;

  // Counts overwrite pulses of the working buffer.
  always @(posedge clk) begin
    if (buf1_clobber === 1'b1) clob_n++;
  end

  task automatic mism(input logic [127:0] got, input logic [127:0] exp);
    failures++;
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  task automatic cmp_map(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) mism(got, exp);
  endtask

  task automatic cmp_blk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) mism({111'h0, got}, {111'h0, exp});
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) mism({120'h0, got}, {120'h0, exp});
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) mism({127'h0, got}, {127'h0, exp});
  endtask

  // Expected blocked vector: sub-sectors from bit pairs of byte 0, others from whole bytes.
  function automatic logic [16:0] exp_blk(input logic [127:0] m, input logic en);
    logic [16:0] b;
    b[0] = m[127] & m[126];
    b[1] = m[125] & m[124];
    for (int k = 1; k < 16; k++) begin
      b[k + 1] = (m[127 - 8 * k -: 8] == 8'hFF);
    end
    return en ? b : 17'h0_0000;
  endfunction

  // One host request; checks are made at the falling edge so registered outputs have settled.
  task automatic do_cmd(input spm_pkg::spm_cmd_e c, input logic [127:0] m);
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    start <= 1'b1;
    cmd <= c;
    wr_map <= m;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 20000);
    if (n >= 20000) mism(128'h0, 128'h1);
  endtask

  task automatic t_after_reset;
    do_cmd(spm_pkg::CMD_READ, 128'h0);
    cmp_map(rd_map, {16{spm_pkg::MAP_RESET}});
    repeat (4) @(negedge clk);
    cmp_bit(i_spm_if.so_oe, 1'b0);
    // An idle device answers a plain status read with only the ready bit set.
    do_cmd(spm_pkg::CMD_STATUS, 128'h0);
    cmp_byte(status_out, 8'(1 << spm_pkg::STATUS_READY_BIT));
  endtask

  // Erase with protection on: every sector ends up marked.
  task automatic t_erase;
    @(posedge clk);
    prot_en <= 1'b1;
    do_cmd(spm_pkg::CMD_ERASE, 128'h0);
    cmp_bit(status_out[spm_pkg::STATUS_READY_BIT], 1'b1);
    cmp_blk(blocked, 17'h1_FFFF);
    do_cmd(spm_pkg::CMD_READ, 128'h0);
    cmp_map(rd_map, {16{spm_pkg::MAP_ERASED}});
  endtask

  // Program while protection stays on, then drop protection.
  task automatic t_prog;
    int c0;
    c0 = clob_n;
    do_cmd(spm_pkg::CMD_PROG, PAT);
    cmp_bit(clob_n == c0 + 1, 1'b1);
    cmp_blk(blocked, exp_blk(PAT, 1'b1));
    do_cmd(spm_pkg::CMD_READ, 128'h0);
    cmp_map(rd_map, PAT);
    @(posedge clk);
    prot_en <= 1'b0;
    repeat (3) @(negedge clk);
    cmp_blk(blocked, 17'h0_0000);
  endtask

  // The pin alone enables protection and locks the map against erase.
  task automatic t_wp;
    @(posedge clk);
    wp_n <= 1'b0;
    repeat (3) @(negedge clk);
    cmp_blk(blocked, exp_blk(PAT, 1'b1));
    do_cmd(spm_pkg::CMD_ERASE, 128'h0);
    do_cmd(spm_pkg::CMD_READ, 128'h0);
    cmp_map(rd_map, PAT);
    @(posedge clk);
    wp_n <= 1'b1;
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Eight commands of at most a few thousand clocks each, about ten thousand in all; six times that means a hang.
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_after_reset();
    t_erase();
    t_prog();
    t_wp();
    tally_and_finish();
  end
endmodule
